// ### shared/cms_pkg.sv
package cms_pkg;
    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_START_PERIOD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PHASES = 8'h0C;

    // Control register fields and reset value
    localparam int CTRL_OSC_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;

    // Status register field positions
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_TRIP_LSB = 8;
    localparam int STAT_DIR_BIT = 16;

    // Phase code register field positions, two bits per phase
    localparam int PHC_ONE_LSB = 0;
    localparam int PHC_TWO_LSB = 2;
    localparam int PHC_THREE_LSB = 4;

    // Start oscillator period
    localparam int CLK_HZ = 100_000_000;
    localparam int START_TIME_MS = 500;
    localparam int START_CYCLES = START_TIME_MS * (CLK_HZ / 1000);

    // Sequence positions
    localparam logic [2:0] POS_LAST = 3'h5;
    localparam logic [2:0] POS_RESET_FWD = 3'h0;
    localparam logic [2:0] POS_RESET_REV = 3'h1;

    // Drivers: index 2*p is the upper (source) of phase p, 2*p+1 the lower (sink)
    localparam int NUM_PHASES = 3;
    localparam int NUM_DRV = 6;
    localparam logic [5:0] DRV_ALL_LOW = 6'h2A;

    typedef enum logic [1:0] {PH_Z, PH_L, PH_H} cms_phase_t;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_RESET, MODE_TEST, MODE_BRAKE} cms_mode_t;
endpackage

// ### shared/cms_drv_if.sv
interface cms_drv_if;
    import cms_pkg::*;
    logic [NUM_DRV-1:0] demand;
    logic [NUM_DRV-1:0] ovt;
    logic [NUM_DRV-1:0] on;
    logic [NUM_DRV-1:0] trip;

    modport seq (output demand, output ovt, input on, input trip);
    modport stage (input demand, input ovt, output on, output trip);
endinterface

// ### design/cms_drv_stage.sv
module cms_drv_stage
    import cms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    cms_drv_if.stage drv
);
    logic [NUM_DRV-1:0] on_r;
    logic [NUM_DRV-1:0] trip_r;

    // One guarded driver per transistor; the sensor only counts while it is asked to conduct
    for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
        always_ff @(posedge clk_sys) begin
            if (!rstn) begin
                on_r[i] <= 1'b0;
                trip_r[i] <= 1'b0;
            end else begin
                on_r[i] <= drv.demand[i] & ~drv.ovt[i];
                trip_r[i] <= drv.demand[i] & drv.ovt[i];
            end
        end
    end

    assign drv.on = on_r;
    assign drv.trip = trip_r;
endmodule

// ### design/cms_sequencer.sv
// Contract
// - Reset held with direction high gives phase one Z, two low, three high.
// - Six-state sequence per direction; reverse starts at HLZ and wraps around.
// - Brake beats test, test beats reset, reset beats normal running.
// - Each phase is high, low or floating; exactly one floats per state.
// - Each driver has its own thermal sense while on and shuts off when hot.
// - Brake forces all three phases low by turning on all three sink drivers.
// - Commutation pulses restart the start oscillator; its expiry advances one state.
module cms_sequencer
    import cms_pkg::*;
#(
    parameter int START_CYC = START_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic direction,
    input wire logic brake,
    input wire logic test_mode,
    input wire logic reset_input_level,
    input wire logic comm_pulse,
    input wire logic [NUM_DRV-1:0] ovt_in,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic start_pulse,
    output logic phase_one_out,
    output logic phase_one_out_oe_n,
    output logic phase_two_out,
    output logic phase_two_out_oe_n,
    output logic phase_three_out,
    output logic phase_three_out_oe_n
);
    cms_drv_if drv();

    cms_drv_stage u_stage (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .drv(drv.stage)
    );

    cms_mode_t mode_c;
    logic [2:0] pos_r;
    logic [2:0] pos_nxt;
    logic [31:0] ctrl_r;
    logic [31:0] period_r;
    logic [31:0] osc_cnt_r;
    logic [DATA_W-1:0] rdata_r;
    logic osc_expire;
    logic advance;
    cms_phase_t [NUM_PHASES-1:0] codes_c;
    logic [NUM_DRV-1:0] demand_c;

    // Fixed priority among the control pins
    always_comb begin
        if (brake) begin
            mode_c = MODE_BRAKE;
        end else if (test_mode) begin
            mode_c = MODE_TEST;
        end else if (reset_input_level) begin
            mode_c = MODE_RESET;
        end else begin
            mode_c = MODE_NORMAL;
        end
    end

    // Start oscillator; period zero disables it rather than firing every cycle
    assign osc_expire = ctrl_r[CTRL_OSC_EN_BIT] && (period_r != 32'h00000000)
                        && (osc_cnt_r >= period_r - 32'h00000001);
    assign start_pulse = osc_expire && (mode_c == MODE_NORMAL) && !comm_pulse;

    // Counter held at zero while disabled, so enabling cannot fire a stale expiry
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            osc_cnt_r <= 32'h00000000;
        end else if (comm_pulse || mode_c != MODE_NORMAL || osc_expire || !ctrl_r[CTRL_OSC_EN_BIT]) begin
            osc_cnt_r <= 32'h00000000;
        end else begin
            osc_cnt_r <= osc_cnt_r + 32'h00000001;
        end
    end

    // Test mode steps only on commutation strobes, so the oscillator cannot disturb it
    assign advance = (mode_c == MODE_NORMAL && (comm_pulse || start_pulse))
                     || (mode_c == MODE_TEST && comm_pulse);

    // One position per strobe; reverse walks the same ring backwards
    always_comb begin
        if (direction) begin
            pos_nxt = (pos_r == POS_LAST) ? 3'h0 : pos_r + 3'h1;
        end else begin
            pos_nxt = (pos_r == 3'h0) ? POS_LAST : pos_r - 3'h1;
        end
    end

    // Brake holds the position so running resumes where it stopped
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pos_r <= POS_RESET_FWD;
        end else if (mode_c == MODE_RESET) begin
            pos_r <= direction ? POS_RESET_FWD : POS_RESET_REV;
        end else if (advance) begin
            pos_r <= pos_nxt;
        end
    end

    // Position to phase codes: ZLH HLZ HZL ZHL LHZ LZH
    always_comb begin
        case (pos_r)
            3'h0: codes_c = '{PH_H, PH_L, PH_Z};
            3'h1: codes_c = '{PH_Z, PH_L, PH_H};
            3'h2: codes_c = '{PH_L, PH_Z, PH_H};
            3'h3: codes_c = '{PH_L, PH_H, PH_Z};
            3'h4: codes_c = '{PH_Z, PH_H, PH_L};
            3'h5: codes_c = '{PH_H, PH_Z, PH_L};
            default: codes_c = '{PH_Z, PH_Z, PH_Z};
        endcase
    end

    // Driver demand per phase; brake turns on every sink
    always_comb begin
        demand_c = '0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            if (mode_c == MODE_BRAKE) begin
                demand_c[2*p+1] = 1'b1;
            end else begin
                demand_c[2*p] = (codes_c[p] == PH_H);
                demand_c[2*p+1] = (codes_c[p] == PH_L);
            end
        end
    end

    assign drv.demand = demand_c;
    assign drv.ovt = ovt_in;

    // Pins follow the registered driver state; a tripped driver floats its pin
    assign phase_one_out = drv.on[0];
    assign phase_one_out_oe_n = ~(drv.on[0] | drv.on[1]);
    assign phase_two_out = drv.on[2];
    assign phase_two_out_oe_n = ~(drv.on[2] | drv.on[3]);
    assign phase_three_out = drv.on[4];
    assign phase_three_out_oe_n = ~(drv.on[4] | drv.on[5]);

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RESET;
            period_r <= 32'(START_CYC);
        end else if (reg_wr) begin
            if (reg_addr == OFS_CTRL) begin
                ctrl_r <= reg_wdata & 32'h00000001;
            end
            if (reg_addr == OFS_START_PERIOD) begin
                period_r <= reg_wdata;
            end
        end
    end

    // Register reads: data in the following cycle only, unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: rdata_r <= ctrl_r;
                OFS_START_PERIOD: rdata_r <= period_r;
                OFS_STATUS: begin
                    rdata_r <= 32'h00000000;
                    rdata_r[STAT_POS_LSB +: 3] <= pos_r;
                    rdata_r[STAT_MODE_LSB +: 2] <= mode_c;
                    rdata_r[STAT_TRIP_LSB +: NUM_DRV] <= drv.trip;
                    rdata_r[STAT_DIR_BIT] <= direction;
                end
                OFS_PHASES: begin
                    rdata_r <= 32'h00000000;
                    rdata_r[PHC_ONE_LSB +: 2] <= codes_c[0];
                    rdata_r[PHC_TWO_LSB +: 2] <= codes_c[1];
                    rdata_r[PHC_THREE_LSB +: 2] <= codes_c[2];
                end
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_r;

    a_reset_fwd_state:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (mode_c == MODE_RESET && direction && ovt_in == 6'h00)[*3]
        |-> drv.on == 6'h18 && !phase_three_out_oe_n && phase_one_out_oe_n)
        else $error("reset with forward direction did not give Z L H");

    a_step_order:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (advance && !direction && pos_r == 3'h0) |=> pos_r == POS_LAST)
        else $error("reverse step from first position did not wrap to last");

    a_brake_wins:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (brake |-> mode_c == MODE_BRAKE) and (!brake && test_mode |-> mode_c == MODE_TEST))
        else $error("control priority resolved wrongly");

    a_one_float:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        mode_c != MODE_BRAKE |-> $countones(demand_c) == 2
        && $countones(demand_c & 6'h15) == 1 && $countones(demand_c & DRV_ALL_LOW) == 1)
        else $error("commutation state does not float exactly one phase");

    a_hot_off:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 ((drv.on & $past(ovt_in)) == 6'h00) && ((drv.trip & ~$past(demand_c)) == 6'h00))
        else $error("driver stayed on while hot or tripped while off");

    a_brake_all_low:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (brake && ovt_in == 6'h00) |=> drv.on == DRV_ALL_LOW && !phase_one_out && !phase_two_out)
        else $error("brake did not force every phase low");

    a_start_restart:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        comm_pulse ##1 (!comm_pulse && mode_c == MODE_NORMAL && ctrl_r[CTRL_OSC_EN_BIT] && !osc_expire)
        |=> osc_cnt_r == 32'h00000001)
        else $error("commutation pulse did not restart the start oscillator");

    a_single_step:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (mode_c == MODE_NORMAL && advance && direction)
        |=> pos_r == (($past(pos_r) == POS_LAST) ? 3'h0 : $past(pos_r) + 3'h1))
        else $error("strobe did not advance exactly one position");

    a_hold_idle:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (!advance && mode_c != MODE_RESET) |=> $stable(pos_r))
        else $error("position moved without a strobe");
endmodule

// ### bench/cms_motor_model.sv
// Far side: the three winding ends seen as Z, L or H, coded like the phase register
module cms_motor_model
    import cms_pkg::*;
(
    input wire logic [2:0] pin,
    input wire logic [2:0] oe_n,
    output logic [5:0] code,
    output logic [1:0] floats
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released end carries no level of its own, so it reads as Z whatever the pin holds
    always_comb begin
        floats = 2'h0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            code[2*p +: 2] = oe_n[p] ? 2'h0 : (pin[p] ? 2'h2 : 2'h1);
            floats = floats + {1'b0, oe_n[p]};
        end
    end
endmodule

// ### bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cms_pkg::*;

    // Short start period keeps the oscillator test brief
    localparam int PER = 20;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic direction = 1'b1, brake = 1'b0, test_mode = 1'b0, reset_input_level = 1'b0, comm_pulse = 1'b0;
    logic [5:0] ovt_in = 6'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic reg_wr = 1'b0, reg_rd = 1'b0, start_pulse;
    logic [2:0] pin, oe_n;
    logic [5:0] code;
    logic [1:0] floats;
    int err_total = 0, compares = 0, cyc = 0, k;
    logic [5:0] ring [6] = '{6'h24, 6'h06, 6'h12, 6'h18, 6'h09, 6'h21};

    cms_sequencer #(.START_CYC(PER)) uut (.clk_sys(clk_sys), .rstn(rstn), .direction(direction),
        .brake(brake), .test_mode(test_mode), .reset_input_level(reset_input_level),
        .comm_pulse(comm_pulse), .ovt_in(ovt_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_pulse(start_pulse),
        .phase_one_out(pin[0]), .phase_one_out_oe_n(oe_n[0]), .phase_two_out(pin[1]),
        .phase_two_out_oe_n(oe_n[1]), .phase_three_out(pin[2]), .phase_three_out_oe_n(oe_n[2]));
    cms_motor_model motor (.pin(pin), .oe_n(oe_n), .code(code), .floats(floats));

    always #5 clk_sys = ~clk_sys;

    task automatic summarize();
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 140 cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // Pins follow the position one edge after it moves
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic step(input logic [5:0] exp);
        @(posedge clk_sys);
        comm_pulse <= 1'b1;
        @(posedge clk_sys);
        comm_pulse <= 1'b0;
        settle();
        cmp("phases", {26'h0, exp}, {26'h0, code});
        cmp("floating", 32'h1, {30'h0, floats});
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(OFS_CTRL);
        cmp("ctrl", CTRL_RESET, rd_val);
        rd(8'hF0);
        cmp("unmapped", 32'h0, rd_val);
        // Oscillator off so only strobes move the ring
        wr(OFS_CTRL, 32'h0);
        @(posedge clk_sys);
        reset_input_level <= 1'b1;
        settle();
        cmp("reset fwd", 32'h24, {26'h0, code});
        @(posedge clk_sys);
        reset_input_level <= 1'b0;
        for (int i = 1; i <= 6; i++)
            step(ring[i % 6]);
        @(posedge clk_sys);
        direction <= 1'b0;
        reset_input_level <= 1'b1;
        settle();
        cmp("reset rev", 32'h06, {26'h0, code});
        @(posedge clk_sys);
        reset_input_level <= 1'b0;
        for (int i = 0; i < 6; i++)
            step(ring[(6 - i) % 6]);
        // Two strobes on adjacent edges give two steps
        @(posedge clk_sys);
        direction <= 1'b1;
        comm_pulse <= 1'b1;
        repeat (2) @(posedge clk_sys);
        comm_pulse <= 1'b0;
        rd(OFS_STATUS);
        cmp("position", 32'h3, {29'h0, rd_val[2:0]});
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            brake <= m[2];
            test_mode <= m[1];
            reset_input_level <= m[0];
            rd(OFS_STATUS);
            cmp("mode", m[2] ? 32'h3 : m[1] ? 32'h2 : {31'h0, m[0]}, {30'h0, rd_val[5:4]});
            if (m[2])
                cmp("brake phases", 32'h15, {26'h0, code});
        end
        @(posedge clk_sys);
        brake <= 1'b0;
        test_mode <= 1'b0;
        reset_input_level <= 1'b0;
        settle();
        @(posedge clk_sys);
        ovt_in <= 6'h11;
        settle();
        cmp("hot phases", 32'h04, {26'h0, code});
        rd(OFS_STATUS);
        cmp("trip", 32'h10, {26'h0, rd_val[13:8]});
        cmp("direction", 32'h1, {31'h0, rd_val[16]});
        @(posedge clk_sys);
        ovt_in <= 6'h00;
        settle();
        cmp("cool phases", 32'h24, {26'h0, code});
        rd(OFS_PHASES);
        cmp("phase reg", 32'h24, rd_val);
        rd(OFS_START_PERIOD);
        cmp("period", PER, rd_val);
        wr(OFS_CTRL, 32'h1);
        @(posedge clk_sys);
        comm_pulse <= 1'b1;
        @(posedge clk_sys);
        comm_pulse <= 1'b0;
        #1 k = 0;
        while (start_pulse !== 1'b1 && k < 40) begin
            @(posedge clk_sys);
            #1 k++;
        end
        cmp("start gap", PER - 1, k);
        rd(OFS_STATUS);
        cmp("start step", 32'h2, {29'h0, rd_val[2:0]});
        // Test mode still steps on a commutation strobe
        @(posedge clk_sys);
        test_mode <= 1'b1;
        step(6'h18);
        summarize();
    end
endmodule
